// file: rtl/brf_top.sv
// Balloon retention flop bank with APB control, checks and sticky violation.
// Assumes cell-side pins are asynchronous to pclk and change slower than 3 pclk cycles.
//
// Operation
// - clock held low, high or unchanged in retention
// - both-stage restore needs no-change, slave needs low
// - preset and clear override the clock
// - check preset/clear at their trailing edge
// - save and restore inactive in normal operation
// - pins are save, restore or combined
// - level save captures at trailing edge
// - edge restore action marks output time
// - restore style edge, leading or trailing; default leading
// - edge style restores then resumes at once
// - leading style restores early, resumes after trailing
// - trailing style restores and resumes at trailing
// - check conditions at save and restore points
// - normal mode loads data each clock rise
// - restore presets or clears main from balloon
// - balloon transparent during level save, samples at an edge save, holds otherwise
// - bank replicates bits with shared controls
`include "brf_defines.svh"

module brf_top #(
	parameter int BITS = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`BRF_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cell_clk,
	input wire logic [BITS-1:0] data_in,
	input wire logic cell_preset,
	input wire logic cell_clear,
	input wire logic save_pin,
	input wire logic restore_pin,
	input wire logic primary_off,
	output logic [BITS-1:0] main_bit,
	output logic [BITS-1:0] balloon_bit,
	output logic violation
);

	localparam int SW = BITS + `BRF_CTL_PINS;

	typedef struct packed {
		logic [SW-1:0] sync1;
		logic [SW-1:0] sync2;
		logic [`BRF_CTL_PINS-1:0] prev;
		logic [`BRF_CTRL_W-1:0] ctrl;
		logic [`BRF_CAUSE_W-1:0] cause;
		logic pending;
		logic [31:0] prdata;
	} brf_top_state_s;

	brf_top_state_s st;
	brf_top_state_s next_st;

	function automatic logic level_active(input brf_pkg::brf_action_e act, input logic lvl);
		level_active = (act == brf_pkg::brf_act_high || act == brf_pkg::brf_act_rise) ? lvl : !lvl;
	endfunction : level_active

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised pins and decoded configuration

	logic clk_s;
	logic clk_p;
	logic save_s;
	logic save_p;
	logic rest_s;
	logic rest_p;
	logic pre_s;
	logic pre_p;
	logic clr_s;
	logic clr_p;
	logic off_s;
	logic [BITS-1:0] din_s;
	brf_pkg::brf_style_e style;
	brf_pkg::brf_action_e save_act;
	brf_pkg::brf_action_e rest_act;
	brf_pkg::brf_hold_e hold;
	logic combined;
	logic target_both;

	assign clk_s = st.sync2[0];
	assign save_s = st.sync2[1];
	assign rest_s = st.sync2[2];
	assign pre_s = st.sync2[3];
	assign clr_s = st.sync2[4];
	assign off_s = st.sync2[5];
	assign din_s = st.sync2[SW-1:`BRF_CTL_PINS];
	assign clk_p = st.prev[0];
	assign save_p = st.prev[1];
	assign rest_p = st.prev[2];
	assign pre_p = st.prev[3];
	assign clr_p = st.prev[4];

	assign style = brf_pkg::brf_style_e'(st.ctrl[`BRF_CTRL_STYLE_LSB +: 2]);
	assign save_act = brf_pkg::brf_action_e'(st.ctrl[`BRF_CTRL_SAVE_ACT_LSB +: 2]);
	assign rest_act = brf_pkg::brf_action_e'(st.ctrl[`BRF_CTRL_REST_ACT_LSB +: 2]);
	assign hold = brf_pkg::brf_hold_e'(st.ctrl[`BRF_CTRL_HOLD_LSB +: 2]);
	assign combined = st.ctrl[`BRF_CTRL_COMBINED_BIT];
	assign target_both = st.ctrl[`BRF_CTRL_BOTH_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Save and restore event decode

	logic save_l;
	logic save_lp;
	logic rest_l;
	logic rest_lp;
	logic save_edge_type;
	logic save_rise;
	logic save_fall;
	logic rest_rise;
	logic rest_fall;
	logic save_take;
	logic save_point;
	logic rest_point;
	logic rest_force;
	logic freeze;
	logic clk_rise;
	logic load;

	// A combined pin saves while nothing is pending and restores once a save is held
	always_comb begin
		if (combined) begin
			save_l = !st.pending && level_active(save_act, save_s);
			save_lp = !st.pending && level_active(save_act, save_p);
			rest_l = st.pending && level_active(rest_act, save_s);
			rest_lp = st.pending && level_active(rest_act, save_p);
		end else begin
			save_l = level_active(save_act, save_s);
			save_lp = level_active(save_act, save_p);
			rest_l = level_active(rest_act, rest_s);
			rest_lp = level_active(rest_act, rest_p);
		end
	end

	assign save_rise = save_l && !save_lp;
	assign save_fall = !save_l && save_lp;
	assign rest_rise = rest_l && !rest_lp;
	assign rest_fall = !rest_l && rest_lp;
	assign save_edge_type = (save_act == brf_pkg::brf_act_rise)
		|| (save_act == brf_pkg::brf_act_fall);
	// Level save tracks main while active, so the trailing edge leaves the last value
	assign save_take = save_edge_type ? save_rise : save_l;
	assign save_point = save_edge_type ? save_rise : save_fall;

	// Illegal style code 3 behaves as the leading default
	always_comb begin
		unique case (style)
			brf_pkg::brf_edge_trigger: begin
				rest_force = rest_rise;
				freeze = 1'b0;
				rest_point = rest_rise;
			end
			brf_pkg::brf_trailing: begin
				rest_force = rest_fall;
				freeze = rest_l;
				rest_point = rest_fall;
			end
			default: begin
				rest_force = rest_l;
				freeze = rest_l;
				rest_point = rest_rise;
			end
		endcase
	end

	assign clk_rise = clk_s && !clk_p;
	assign load = clk_rise && !freeze && !off_s;

	////////////////////////////////////////////////////////////////////////////////
	// Condition checks

	logic [`BRF_CAUSE_W-1:0] hits;
	logic hold_bad;

	always_comb begin
		unique case (hold)
			brf_pkg::brf_hold_low: hold_bad = clk_s;
			brf_pkg::brf_hold_high: hold_bad = !clk_s;
			brf_pkg::brf_hold_none: hold_bad = clk_s != clk_p;
			default: hold_bad = 1'b1;
		endcase
	end

	always_comb begin
		hits = '0;
		hits[`BRF_CAUSE_CLOCK] = (off_s && hold_bad)
			|| (!off_s && clk_rise && (save_l || rest_l));
		hits[`BRF_CAUSE_SAVE] = save_point && clk_s;
		hits[`BRF_CAUSE_RESTORE] = rest_point && (clk_s || off_s);
		// In leading and trailing styles a preset or clear that ends inside a restore is overwritten by it
		hits[`BRF_CAUSE_PRECLR] = ((pre_p && !pre_s) || (clr_p && !clr_s)) && rest_l;
		hits[`BRF_CAUSE_RETAIN] = off_s && save_l;
		hits[`BRF_CAUSE_CONFIG] = target_both ? (hold != brf_pkg::brf_hold_none)
			: (hold != brf_pkg::brf_hold_low);
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave and state update

	logic setup;
	logic wr;
	logic mapped;
	logic [31:0] rd_word;

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign mapped = (paddr == `BRF_CTRL_OFFSET) || (paddr == `BRF_STATUS_OFFSET)
		|| (paddr == `BRF_MAIN_OFFSET) || (paddr == `BRF_BALLOON_OFFSET);

	always_comb begin
		rd_word = 32'h0000_0000;
		if (paddr == `BRF_CTRL_OFFSET) begin
			rd_word[`BRF_CTRL_W-1:0] = st.ctrl;
		end else if (paddr == `BRF_STATUS_OFFSET) begin
			rd_word[`BRF_ST_VIOL_BIT] = |st.cause;
			rd_word[`BRF_ST_PENDING_BIT] = st.pending;
			rd_word[`BRF_ST_RESTORE_BIT] = rest_l;
			rd_word[`BRF_ST_SAVE_BIT] = save_l;
			rd_word[`BRF_ST_OFF_BIT] = off_s;
			rd_word[`BRF_CAUSE_LSB +: `BRF_CAUSE_W] = st.cause;
		end else if (paddr == `BRF_MAIN_OFFSET) begin
			rd_word[BITS-1:0] = main_bit;
		end else if (paddr == `BRF_BALLOON_OFFSET) begin
			rd_word[BITS-1:0] = balloon_bit;
		end
	end

	always_comb begin
		next_st = st;
		next_st.sync1 = {data_in, primary_off, cell_clear, cell_preset, restore_pin, save_pin,
			cell_clk};
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2[`BRF_CTL_PINS-1:0];
		// A new save beats a restore that ends in the same cycle
		if (rest_fall) begin
			next_st.pending = 1'b0;
		end
		if (save_point) begin
			next_st.pending = 1'b1;
		end
		if (setup && !pwrite) begin
			next_st.prdata = rd_word;
		end
		if (wr && paddr == `BRF_CTRL_OFFSET) begin
			next_st.ctrl = pwdata[`BRF_CTRL_W-1:0];
		end
		// New hits win over a write-one clear in the same cycle
		if (wr && paddr == `BRF_STATUS_OFFSET) begin
			next_st.cause = (st.cause & ~pwdata[`BRF_CAUSE_LSB +: `BRF_CAUSE_W]) | hits;
		end else begin
			next_st.cause = st.cause | hits;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.sync1 <= '0;
			st.sync2 <= '0;
			st.prev <= '0;
			st.ctrl <= `BRF_CTRL_RESET;
			st.cause <= `BRF_CAUSE_RESET;
			st.pending <= 1'b0;
			st.prdata <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign violation = |st.cause;

	////////////////////////////////////////////////////////////////////////////////
	// Bank of identical bits on shared controls

	for (genvar i = 0; i < BITS; i++) begin : g_bit
		brf_bit u_bit (
			.pclk(pclk),
			.presetn(presetn),
			.d(din_s[i]),
			.load(load),
			.preset(pre_s),
			.clear(clr_s),
			.restore_force(rest_force),
			.power_off(off_s),
			.save_take(save_take),
			.main_bit(main_bit[i]),
			.balloon_bit(balloon_bit[i])
		);
	end

endmodule : brf_top

// file: rtl/brf_defines.svh
// Offsets, field positions, reset values and widths of the retention flop block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BRF_DEFINES_SVH
`define BRF_DEFINES_SVH

`define BRF_ADDR_W 8
`define BRF_CTRL_OFFSET 8'h00
`define BRF_STATUS_OFFSET 8'h04
`define BRF_MAIN_OFFSET 8'h08
`define BRF_BALLOON_OFFSET 8'h0c

`define BRF_CTRL_W 10
`define BRF_CTRL_STYLE_LSB 0
`define BRF_CTRL_SAVE_ACT_LSB 2
`define BRF_CTRL_REST_ACT_LSB 4
`define BRF_CTRL_HOLD_LSB 6
`define BRF_CTRL_COMBINED_BIT 8
`define BRF_CTRL_BOTH_BIT 9
`define BRF_CTRL_RESET 10'h015

`define BRF_CAUSE_W 6
`define BRF_CAUSE_LSB 8
`define BRF_CAUSE_CLOCK 0
`define BRF_CAUSE_SAVE 1
`define BRF_CAUSE_RESTORE 2
`define BRF_CAUSE_PRECLR 3
`define BRF_CAUSE_RETAIN 4
`define BRF_CAUSE_CONFIG 5
`define BRF_CAUSE_RESET 6'h00

`define BRF_ST_VIOL_BIT 0
`define BRF_ST_PENDING_BIT 1
`define BRF_ST_RESTORE_BIT 2
`define BRF_ST_SAVE_BIT 3
`define BRF_ST_OFF_BIT 4

`define BRF_CTL_PINS 6

`endif

// file: rtl/brf_pkg.sv
// Types shared by the retention flop block.
// Assumes nothing beyond a SystemVerilog compiler.
package brf_pkg;

	typedef enum logic [1:0] {
		brf_edge_trigger,
		brf_leading,
		brf_trailing
	} brf_style_e;

	typedef enum logic [1:0] {
		brf_act_low,
		brf_act_high,
		brf_act_rise,
		brf_act_fall
	} brf_action_e;

	typedef enum logic [1:0] {
		brf_hold_low,
		brf_hold_high,
		brf_hold_none
	} brf_hold_e;

	typedef struct packed {
		logic main_bit;
		logic balloon_bit;
	} brf_bit_s;

endpackage : brf_pkg

// file: rtl/brf_bit.sv
// One bit of the retention bank: main flop plus always-powered balloon latch.
// Assumes all control strobes are already synchronised to pclk by the caller.
module brf_bit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	input wire logic load,
	input wire logic preset,
	input wire logic clear,
	input wire logic restore_force,
	input wire logic power_off,
	input wire logic save_take,
	output logic main_bit,
	output logic balloon_bit
);

	brf_pkg::brf_bit_s st;
	brf_pkg::brf_bit_s next_st;

	always_comb begin
		next_st = st;
		// Preset and clear win over restore and clock; the balloon never sees them
		if (clear) begin
			next_st.main_bit = 1'b0;
		end else if (preset) begin
			next_st.main_bit = 1'b1;
		end else if (restore_force) begin
			next_st.main_bit = st.balloon_bit;
		end else if (power_off) begin
			// Main stage content is lost without primary power
			next_st.main_bit = 1'b0;
		end else if (load) begin
			next_st.main_bit = d;
		end
		// Transparent while saving, so the last value before the trailing edge stays
		if (save_take) begin
			next_st.balloon_bit = st.main_bit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign main_bit = st.main_bit;
	assign balloon_bit = st.balloon_bit;

endmodule : brf_bit

// file: verif/brf_pmc.sv
// Power controller model: save pulse then power down, power up then restore.
// Assumes nothing of cell_clk; the bench holds it high across one power-up command.
module brf_pmc (
	input wire logic pclk,
	input wire logic [1:0] cmd,
	input wire logic comb,
	input wire logic [3:0] len,
	output logic save_pin,
	output logic restore_pin,
	output logic primary_off,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////
	// Each level is held long enough for the two-stage input sync
	// One process owns every output, so each pin has a single driver
	initial begin
		save_pin = 1'b0;
		restore_pin = 1'b0;
		primary_off = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge pclk);
			if (cmd != 2'd0) begin
				busy <= 1'b1;
				case (cmd)
					2'd1: begin
						save_pin <= 1'b1;
						repeat (len) @(posedge pclk);
						save_pin <= 1'b0;
						repeat (4) @(posedge pclk);
						primary_off <= 1'b1;
					end
					2'd2: begin
						primary_off <= 1'b0;
						repeat (4) @(posedge pclk);
						if (comb) begin
							save_pin <= 1'b1;
						end else begin
							restore_pin <= 1'b1;
						end
					end
					default: begin
						save_pin <= 1'b0;
						restore_pin <= 1'b0;
					end
				endcase
				repeat (5) @(posedge pclk);
				busy <= 1'b0;
			end
		end
	end
endmodule : brf_pmc

// file: verif/brf_top_assertions.sv
// Pin-level checks on the retention flop bank.
// Assumes save and restore act active high, as the bench configures.
`include "brf_defines.svh"

module brf_top_chk #(
	parameter int BITS = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`BRF_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cell_clk,
	input wire logic [BITS-1:0] data_in,
	input wire logic cell_preset,
	input wire logic cell_clear,
	input wire logic save_pin,
	input wire logic restore_pin,
	input wire logic primary_off,
	input wire logic [BITS-1:0] main_bit,
	input wire logic [BITS-1:0] balloon_bit,
	input wire logic violation
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic quiet;
	logic [5:0] pins;
	assign quiet = !(save_pin || restore_pin || primary_off || cell_preset || cell_clear);
	assign pins = {cell_clk, cell_preset, cell_clear, save_pin, restore_pin, primary_off};
	////////////////////////////////////////
	a_viol_sticky: assert property (
		violation && !(psel && penable && pwrite && paddr == 8'h04) |=> violation)
		else $error("violation dropped without clear");
	a_main_holds: assert property (
		($stable(pins) && !(psel && pwrite))[*6] |-> $stable(main_bit))
		else $error("main changed with no event");
	a_balloon_holds: assert property ((!save_pin)[*6] |-> $stable(balloon_bit))
		else $error("balloon changed outside save");
	a_save_follows: assert property (
		(save_pin && !restore_pin && !primary_off && $stable(main_bit))[*5]
		|-> balloon_bit == main_bit) else $error("balloon not following main");
	a_clk_loads: assert property (
		$rose(cell_clk) && quiet && $stable(data_in) ##1
		(quiet && cell_clk && $stable(data_in))[*4] |-> main_bit == data_in)
		else $error("clock rise did not load data");
	a_preset_forces: assert property (
		(cell_preset && !cell_clear && !primary_off)[*5] |-> main_bit == {BITS{1'b1}})
		else $error("preset not forcing ones");
	a_clear_forces: assert property ((cell_clear && !primary_off)[*5] |-> main_bit == '0)
		else $error("clear not forcing zeros");
	a_preset_trail: assert property (
		$fell(cell_preset) && restore_pin ##1 restore_pin[*4] |-> violation)
		else $error("preset release in restore not flagged");
	a_restore_clk_high: assert property (
		$rose(restore_pin) && cell_clk && !primary_off ##1 (restore_pin && cell_clk)[*4]
		|-> violation) else $error("restore with clock high not flagged");
endmodule : brf_top_chk

bind brf_top brf_top_chk #(.BITS(BITS)) brf_top_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_clk(cell_clk),
	.data_in(data_in), .cell_preset(cell_preset), .cell_clear(cell_clear),
	.save_pin(save_pin), .restore_pin(restore_pin), .primary_off(primary_off),
	.main_bit(main_bit), .balloon_bit(balloon_bit), .violation(violation));

// file: verif/testbench.sv
// Self-checking bench: APB master, cell pin stimulus and the power controller model.
// Assumes the design package, header and checker are compiled before it.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BITS = 2;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, cell_clk, cell_preset;
	logic cell_clear, comb, save_pin, restore_pin, primary_off, busy, violation;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [BITS-1:0] data_in, main_bit, balloon_bit, v, x;
	logic [1:0] cmd;
	logic [3:0] len;
	int n_errors, total_checks, i;
	brf_top #(.BITS(BITS)) brf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cell_clk(cell_clk), .data_in(data_in),
		.cell_preset(cell_preset), .cell_clear(cell_clear), .save_pin(save_pin),
		.restore_pin(restore_pin), .primary_off(primary_off), .main_bit(main_bit),
		.balloon_bit(balloon_bit), .violation(violation));
	brf_pmc brf_pmc_i (.pclk(pclk), .cmd(cmd), .comb(comb), .len(len), .save_pin(save_pin),
		.restore_pin(restore_pin), .primary_off(primary_off), .busy(busy));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] g);
		total_checks++;
		if (g !== ex) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, ex, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic pmc(input logic [1:0] c);
		cmd <= c;
		len <= 4'd3 + 4'($urandom % 6);
		@(posedge pclk);
		cmd <= 2'd0;
		do @(posedge pclk); while (busy !== 1'b0);
	endtask : pmc
	// Data settles through the sync before the clock edge reaches the flop
	task automatic clkp(input logic [BITS-1:0] d);
		data_in <= d;
		repeat (3) @(posedge pclk);
		cell_clk <= 1'b1;
		repeat (6) @(posedge pclk);
		cell_clk <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : clkp
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		complete_run;
	end
	////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, cell_clk, cell_preset, cell_clear, comb} = '0;
		paddr = '0;
		pwdata = '0;
		data_in = '0;
		cmd = 2'd0;
		len = 4'd3;
		void'($urandom(20843));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl reset", 32'h015, r);
		apb(1'b0, 8'h04, 32'h0);
		chk("status reset", 32'h0, r);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped pslverr", 32'h1, 32'(e));
		// Styles edge, leading, trailing, then combined pin in leading style
		for (i = 0; i < 4; i++) begin
			comb <= (i == 3);
			// Edge style also runs an edge-type save; the others save on the level
			apb(1'b1, 8'h00, (i == 3) ? 32'h115 : (i == 0) ? 32'h018
				: (32'h014 | 32'(i)));
			v = BITS'($urandom % 3 + 1);
			clkp(v);
			chk("main load", 32'(v), 32'(main_bit));
			apb(1'b0, 8'h08, 32'h0);
			chk("main reg", 32'(v), r);
			pmc(2'd1);
			chk("balloon saved", 32'(v), 32'(balloon_bit));
			apb(1'b0, 8'h0c, 32'h0);
			chk("balloon reg", 32'(v), r);
			chk("main lost", 32'h0, 32'(main_bit));
			pmc(2'd2);
			chk("main in restore", (i == 2) ? 32'h0 : 32'(v), 32'(main_bit));
			pmc(2'd3);
			chk("main restored", 32'(v), 32'(main_bit));
			x = BITS'($urandom);
			clkp(x);
			chk("main resumes", 32'(x), 32'(main_bit));
			apb(1'b0, 8'h04, 32'h0);
			chk("clean cycle", 32'h0, r & 32'h3f01);
		end
		comb <= 1'b0;
		apb(1'b1, 8'h00, 32'h015);
		cell_preset <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("preset", 32'({BITS{1'b1}}), 32'(main_bit));
		cell_clear <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("clear wins", 32'h0, 32'(main_bit));
		chk("balloon untouched", 32'(v), 32'(balloon_bit));
		cell_preset <= 1'b0;
		cell_clear <= 1'b0;
		pmc(2'd1);
		pmc(2'd2);
		cell_preset <= 1'b1;
		pmc(2'd3);
		cell_preset <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("preset outlasts", 32'({BITS{1'b1}}), 32'(main_bit));
		apb(1'b0, 8'h04, 32'h0);
		chk("preset legal", 32'h0, r & 32'h3f01);
		pmc(2'd1);
		pmc(2'd2);
		cell_preset <= 1'b1;
		repeat (6) @(posedge pclk);
		cell_preset <= 1'b0;
		repeat (6) @(posedge pclk);
		pmc(2'd3);
		apb(1'b0, 8'h04, 32'h0);
		chk("preset cause", 32'h1, 32'(r[11]));
		chk("violation pin", 32'h1, 32'(violation));
		apb(1'b1, 8'h04, 32'h3f00);
		chk("violation clear", 32'h0, 32'(violation));
		pmc(2'd1);
		cell_clk <= 1'b1;
		pmc(2'd2);
		cell_clk <= 1'b0;
		pmc(2'd3);
		apb(1'b0, 8'h04, 32'h0);
		chk("restore clk cause", 32'h1, 32'(r[10]));
		apb(1'b1, 8'h04, 32'h3f00);
		apb(1'b1, 8'h00, 32'h215);
		apb(1'b0, 8'h04, 32'h0);
		chk("both with hold low", 32'h1, 32'(r[13]));
		apb(1'b1, 8'h00, 32'h295);
		apb(1'b1, 8'h04, 32'h3f00);
		apb(1'b0, 8'h04, 32'h0);
		chk("both with no change", 32'h0, 32'(r[13]));
		complete_run;
	end
endmodule : testbench
